// [common/phy_status_map.svh]
`ifndef PHY_STATUS_MAP_SVH
`define PHY_STATUS_MAP_SVH

// Register offsets on the management register port
`define PHY_STATUS_SUMMARY_OFS   5'h10
`define PHY_SPECIFIC_CONTROL_OFS 5'h11
`define MGMT_ADDR_W              5

// Status summary field positions
`define STS_JABBER_BIT   5
`define STS_AN_DONE_BIT  4
`define STS_LOOPBACK_BIT 3
`define STS_DUPLEX_BIT   2
`define STS_SPEED_BIT    1
`define STS_LINK_BIT     0

// Specific control field positions
`define CTL_PLL_DIS_BIT   15
`define CTL_PS_EN_BIT     14
`define CTL_PS_MODE_HI    13
`define CTL_PS_MODE_LO    12
`define CTL_SCR_BYP_BIT   11
`define CTL_RSVD10_BIT    10

// Control reset value and power-save mode encodings
`define CTL_RESET_VAL     6'h00
`define PS_MODE_NORMAL    2'h0
`define PS_MODE_RESERVED  2'h1
`define PS_MODE_ACTIVE    2'h2
`define PS_MODE_PASSIVE   2'h3

// Link pulse interval in active sleep
`define CLK_FREQ_HZ       50000000
`define NLP_INTERVAL_MS   1400
`define NLP_PERIOD_CYC    (`NLP_INTERVAL_MS * (`CLK_FREQ_HZ / 1000))
`define NLP_CNT_W         27

`endif

// [common/phy_status_pkg.sv]
`include "phy_status_map.svh"

package phy_status_pkg;

  // Live status levels from the PHY core
  typedef struct packed {
    logic jabber;
    logic an_done;
    logic loopback;
    logic full_duplex;
    logic speed_10;
    logic link_up;
  } core_status_t;

  // Stored bits 15:10 of the specific control register
  typedef struct packed {
    logic       pll_disable;
    logic       ps_enable;
    logic [1:0] ps_mode;
    logic       scr_bypass;
    logic       rsvd10;
  } ctrl_reg_t;

  typedef enum logic [2:0] {
    PWR_RUN     = 3'b001,
    PWR_ACTIVE  = 3'b010,
    PWR_PASSIVE = 3'b100
  } pwr_state_t;

  // Whole state of the register block
  typedef struct packed {
    pwr_state_t  state;
    ctrl_reg_t   ctrl;
    logic [15:0] rdata;
    logic        rvalid;
    logic        pll_off;
    logic        scr_bypass;
    logic        core_down;
  } ctl_state_t;

  // Whole state of the link pulse timer
  typedef struct packed {
    logic [`NLP_CNT_W-1:0] cnt;
    logic                  tick;
  } nlp_timer_t;

endpackage

// [rtl/nlp_interval_timer.sv]
`timescale 1ns/10ps
`default_nettype none
`include "phy_status_map.svh"

module nlp_interval_timer #(
  parameter logic [`NLP_CNT_W-1:0] PERIOD_CYC = `NLP_CNT_W'(`NLP_PERIOD_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  output logic      tick
);

  phy_status_pkg::nlp_timer_t s_q;
  phy_status_pkg::nlp_timer_t s_d;

  // Count while running, pulse once per period, restart from zero when stopped
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == PERIOD_CYC - 1'b1) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

`default_nettype wire

// [rtl/phy_status_and_power_control.sv]
//
// Contract
// - Status bit 5 reports jabber, meaningful only at 10 Mbps.
// - Jabber bit mirrors basic mode status; reading the summary never clears it.
// - Status bit 4 is 1 once auto-negotiation completed, else 0.
// - Status bit 3 is 1 while loopback is enabled, else 0.
// - Status bit 2 is 1 for full duplex, 0 for half duplex.
// - Status bit 1 is 1 for 10 Mbps, 0 for 100 Mbps.
// - Status bit 0 is 1 with a valid link at either speed.
// - Link bit mirrors basic mode status; reading the summary never clears it.
// - Control bit 15 disables clocks, honoured only in IEEE power-down.
// - Power-save mode field acts only while control bit 14 is set.
// - Mode field 13:12: 00 normal, 01 reserved, 10 active sleep.
// - Active sleep: core down, link pulse every 1.4 s, wake on partner.
// - Passive sleep: core down, no link pulses, wake on partner.
//
`timescale 1ns/10ps
`default_nettype none
`include "phy_status_map.svh"

module phy_status_and_power_control #(
  parameter logic [`NLP_CNT_W-1:0] NLP_PERIOD_CYC = `NLP_CNT_W'(`NLP_PERIOD_CYC)
) (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  // Management register port
  input  wire logic [`MGMT_ADDR_W-1:0]     mgmt_addr,
  input  wire logic                        mgmt_wr,
  input  wire logic                        mgmt_rd,
  input  wire logic [15:0]                 mgmt_wdata,
  output logic      [15:0]                 mgmt_rdata,
  output logic                             mgmt_rvalid,
  // Live levels from the PHY core
  input  wire phy_status_pkg::core_status_t core_sts,
  input  wire logic                        ieee_power_down,
  input  wire logic                        energy_detect,
  // Controls toward the PHY core
  output logic                             pll_off,
  output logic                             scrambler_bypass,
  output logic                             core_power_down,
  output logic                             nlp_send,
  output phy_status_pkg::pwr_state_t       power_state
);

  phy_status_pkg::ctl_state_t s_q;
  phy_status_pkg::ctl_state_t s_d;
  logic [15:0]                sts_word;
  logic [15:0]                ctl_word;
  logic                       sleep_active_req;
  logic                       sleep_passive_req;
  logic                       nlp_tick;
  logic                       nlp_q;

  // Status summary word, built from live levels so a read never clears a bit
  always_comb begin
    sts_word                    = 16'h0000;
    sts_word[`STS_JABBER_BIT]   = core_sts.jabber & core_sts.speed_10;
    sts_word[`STS_AN_DONE_BIT]  = core_sts.an_done;
    sts_word[`STS_LOOPBACK_BIT] = core_sts.loopback;
    sts_word[`STS_DUPLEX_BIT]   = core_sts.full_duplex;
    sts_word[`STS_SPEED_BIT]    = core_sts.speed_10;
    sts_word[`STS_LINK_BIT]     = core_sts.link_up;
  end

  // Control word as seen on readback; bits below 10 belong elsewhere and read zero
  always_comb begin
    ctl_word                                   = 16'h0000;
    ctl_word[`CTL_PLL_DIS_BIT]                 = s_q.ctrl.pll_disable;
    ctl_word[`CTL_PS_EN_BIT]                   = s_q.ctrl.ps_enable;
    ctl_word[`CTL_PS_MODE_HI:`CTL_PS_MODE_LO]  = s_q.ctrl.ps_mode;
    ctl_word[`CTL_SCR_BYP_BIT]                 = s_q.ctrl.scr_bypass;
    ctl_word[`CTL_RSVD10_BIT]                  = s_q.ctrl.rsvd10;
  end

  // Sleep is requested only with the enable set and a sleep code selected
  assign sleep_active_req  = s_q.ctrl.ps_enable && (s_q.ctrl.ps_mode == `PS_MODE_ACTIVE);
  assign sleep_passive_req = s_q.ctrl.ps_enable && (s_q.ctrl.ps_mode == `PS_MODE_PASSIVE);

  // Next state: register writes, readback, power-save sequencing, output controls
  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;

    // Register write to the specific control register
    if (mgmt_wr && (mgmt_addr == `PHY_SPECIFIC_CONTROL_OFS)) begin
      s_d.ctrl.pll_disable = mgmt_wdata[`CTL_PLL_DIS_BIT];
      s_d.ctrl.ps_enable   = mgmt_wdata[`CTL_PS_EN_BIT];
      s_d.ctrl.ps_mode     = mgmt_wdata[`CTL_PS_MODE_HI:`CTL_PS_MODE_LO];
      s_d.ctrl.scr_bypass  = mgmt_wdata[`CTL_SCR_BYP_BIT];
      s_d.ctrl.rsvd10      = mgmt_wdata[`CTL_RSVD10_BIT];
    end

    // Register read; unmapped offsets return zero
    if (mgmt_rd) begin
      s_d.rvalid = 1'b1;
      case (mgmt_addr)
        `PHY_STATUS_SUMMARY_OFS:   s_d.rdata = sts_word;
        `PHY_SPECIFIC_CONTROL_OFS: s_d.rdata = ctl_word;
        default:                   s_d.rdata = 16'h0000;
      endcase
    end

    // Power-save sequencing; a detected partner always wakes the core
    case (s_q.state)
      phy_status_pkg::PWR_RUN: begin
        if (sleep_active_req && !energy_detect) begin
          s_d.state = phy_status_pkg::PWR_ACTIVE;
        end else if (sleep_passive_req && !energy_detect) begin
          s_d.state = phy_status_pkg::PWR_PASSIVE;
        end
      end
      phy_status_pkg::PWR_ACTIVE: begin
        if (energy_detect || !sleep_active_req) begin
          s_d.state = phy_status_pkg::PWR_RUN;
        end
      end
      phy_status_pkg::PWR_PASSIVE: begin
        if (energy_detect || !sleep_passive_req) begin
          s_d.state = phy_status_pkg::PWR_RUN;
        end
      end
      default: begin
        s_d.state = phy_status_pkg::PWR_RUN;
      end
    endcase

    // Core stays powered in normal and reserved modes
    s_d.core_down  = (s_d.state != phy_status_pkg::PWR_RUN);
    // Clock shutdown obeyed only while in IEEE power-down
    s_d.pll_off    = s_d.ctrl.pll_disable && ieee_power_down;
    s_d.scr_bypass = s_d.ctrl.scr_bypass;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q.state   <= phy_status_pkg::PWR_RUN;
      s_q.ctrl    <= `CTL_RESET_VAL;
      s_q.rdata   <= 16'h0000;
      s_q.rvalid  <= 1'b0;
      s_q.pll_off <= 1'b0;
      s_q.scr_bypass <= 1'b0;
      s_q.core_down  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Link pulse cadence runs only in active sleep, none in passive sleep
  nlp_interval_timer #(
    .PERIOD_CYC (NLP_PERIOD_CYC)
  ) u_nlp_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .run     (s_q.state == phy_status_pkg::PWR_ACTIVE),
    .tick    (nlp_tick)
  );

  // Retime the pulse so the output comes straight from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nlp_q <= 1'b0;
    end else begin
      // Gate on the state being entered so no pulse escapes on the wake-up edge
      nlp_q <= nlp_tick && (s_d.state == phy_status_pkg::PWR_ACTIVE);
    end
  end

  assign mgmt_rdata       = s_q.rdata;
  assign mgmt_rvalid      = s_q.rvalid;
  assign pll_off          = s_q.pll_off;
  assign scrambler_bypass = s_q.scr_bypass;
  assign core_power_down  = s_q.core_down;
  assign power_state      = s_q.state;
  assign nlp_send         = nlp_q;

endmodule

`default_nettype wire

// [rtl/nlp_interval_timer_fix_note_unused.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [testbench/phy_status_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_status_checker (
  input wire logic                        ref_clk,
  input wire logic                        sys_rst,
  input wire logic [4:0]                  mgmt_addr,
  input wire logic                        mgmt_rd,
  input wire logic [15:0]                 mgmt_rdata,
  input wire logic                        mgmt_rvalid,
  input wire phy_status_pkg::core_status_t core_sts,
  input wire logic                        ieee_power_down,
  input wire logic                        energy_detect,
  input wire logic                        pll_off,
  input wire logic                        core_power_down,
  input wire logic                        nlp_send,
  input wire phy_status_pkg::pwr_state_t   power_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Read port answers exactly one cycle after each strobe
  rd_answer_a: assert property (mgmt_rd |=> mgmt_rvalid) else $error("read not answered");
  rd_quiet_a: assert property (!mgmt_rd |=> !mgmt_rvalid) else $error("spurious read valid");
  status_word_a: assert property (mgmt_rd && mgmt_addr == 5'h10 |=>
    mgmt_rdata[5:0] == {$past(core_sts.jabber & core_sts.speed_10), $past(core_sts[4:0])})
    else $error("status word wrong");
  unmapped_zero_a: assert property (mgmt_rd && mgmt_addr != 5'h10 && mgmt_addr != 5'h11 |=>
    mgmt_rdata == 16'h0) else $error("unmapped read not zero");
  // Clock disable needs power-down on the previous edge
  pll_gate_a: assert property (pll_off |-> $past(ieee_power_down)) else $error("pll off outside power-down");
  wake_up_a: assert property (energy_detect && power_state != phy_status_pkg::PWR_RUN |=>
    power_state == phy_status_pkg::PWR_RUN) else $error("no wake on energy");
  nlp_state_a: assert property (nlp_send |-> power_state == phy_status_pkg::PWR_ACTIVE)
    else $error("link pulse outside active sleep");
  nlp_pulse_a: assert property (nlp_send |=> !nlp_send) else $error("link pulse too long");
  down_match_a: assert property (core_power_down == (power_state != phy_status_pkg::PWR_RUN))
    else $error("core down disagrees with state");
endmodule
`default_nettype wire

// [testbench/mgmt_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model (
  input wire logic        ref_clk,
  output logic     [4:0]  mgmt_addr,
  output logic            mgmt_wr,
  output logic            mgmt_rd,
  output logic     [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        mgmt_rvalid
);
  initial begin
    mgmt_addr = 5'h1f;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0;
  end
  // One write; released lines show the inverse so stale values never match
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_addr <= a;
    mgmt_wdata <= d;
    mgmt_wr <= 1'b1;
    @(posedge ref_clk);
    mgmt_wr <= 1'b0;
    mgmt_addr <= ~a;
    mgmt_wdata <= ~d;
  endtask
  // One read, data taken at the edge that samples valid high
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic ok);
    @(posedge ref_clk);
    mgmt_addr <= a;
    mgmt_rd <= 1'b1;
    @(posedge ref_clk);
    mgmt_rd <= 1'b0;
    mgmt_addr <= ~a;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge ref_clk);
      ok = (mgmt_rvalid === 1'b1);
      d = mgmt_rdata;
    end
  endtask
endmodule
`default_nettype wire

// [testbench/phy_status_and_power_control_test.sv]
`timescale 1ns/10ps
`default_nettype none
module phy_status_and_power_control_test;
  logic ref_clk, sys_rst, mgmt_wr, mgmt_rd, mgmt_rvalid, ieee_power_down, energy_detect, ok;
  logic pll_off, scrambler_bypass, core_power_down, nlp_send;
  logic [4:0] mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata, rd_q;
  phy_status_pkg::core_status_t core_sts;
  phy_status_pkg::pwr_state_t power_state;
  int fail_count, checked, n;
  // Rows: live status in, expected status word bits out
  logic [11:0] rows [6] = '{12'h8a2, 12'h800, 12'h410, 12'h208, 12'h104, 12'h041};
  logic [15:0] modes [5] = '{16'h2000, 16'h4000, 16'h5000, 16'h6000, 16'h7000};
  logic [2:0] states [5] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h4};
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  phy_status_and_power_control #(.NLP_PERIOD_CYC(27'd16)) i_dut (.ref_clk, .sys_rst, .mgmt_addr, .mgmt_wr,
    .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .core_sts, .ieee_power_down, .energy_detect, .pll_off,
    .scrambler_bypass, .core_power_down, .nlp_send, .power_state);
  mgmt_host_model i_host (.ref_clk, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [4:0] a);
    i_host.rd_reg(a, rd_q, ok);
    if (!ok) begin
      fail_count++;
      $display("MISMATCH t=%0t read timeout", $time);
      end_of_test();
    end
  endtask
  task automatic count_nlp(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      n += int'(nlp_send);
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    core_sts = '0;
    ieee_power_down = 1'b0;
    energy_detect = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Each status row read twice: the second read shows nothing was cleared
    foreach (rows[i]) begin
      core_sts <= rows[i][11:6];
      rd(5'h10);
      chk({10'h0, rd_q[5:0]}, {10'h0, rows[i][5:0]});
      rd(5'h10);
      chk({10'h0, rd_q[5:0]}, {10'h0, rows[i][5:0]});
    end
    $display("status rows done");
    rd(5'h11);
    chk(rd_q, 16'h0);
    rd(5'h05);
    chk(rd_q, 16'h0);
    // Enable and mode are always written together
    foreach (modes[i]) begin
      i_host.wr_reg(5'h11, modes[i]);
      // Leaving one sleep for the other passes through run first
      repeat (3) @(posedge ref_clk);
      chk({13'h0, power_state}, {13'h0, states[i]});
      chk({15'h0, core_power_down}, {15'h0, states[i] != 3'h1});
    end
    count_nlp(40);
    chk(16'(n), 16'h0);
    energy_detect <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({13'h0, power_state}, 16'h1);
    energy_detect <= 1'b0;
    i_host.wr_reg(5'h11, 16'h6000);
    count_nlp(56);
    chk(16'(n), 16'h3);
    energy_detect <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({13'h0, power_state}, 16'h1);
    energy_detect <= 1'b0;
    $display("sleep modes done");
    // Clock disable written only while in power-down
    ieee_power_down <= 1'b1;
    i_host.wr_reg(5'h11, 16'hffff);
    rd(5'h11);
    chk(rd_q, 16'hfc00);
    chk({14'h0, pll_off, scrambler_bypass}, 16'h3);
    ieee_power_down <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({15'h0, pll_off}, 16'h0);
    $display("control bits done");
    // Mid-run reset returns every control and output to idle
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk({11'h0, pll_off, scrambler_bypass, core_power_down, nlp_send, mgmt_rvalid}, 16'h0);
    chk({13'h0, power_state}, 16'h1);
    rd(5'h11);
    chk(rd_q, 16'h0);
    $display("reset done");
    end_of_test();
  end
endmodule
bind phy_status_and_power_control phy_status_checker i_chk (.ref_clk, .sys_rst, .mgmt_addr, .mgmt_rd,
  .mgmt_rdata, .mgmt_rvalid, .core_sts, .ieee_power_down, .energy_detect, .pll_off, .core_power_down,
  .nlp_send, .power_state);
`default_nettype wire
